// ==== hw/adc_conversion_sequencer.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_cfg.svh"

// Functional notes
// - Legacy mode signals completion at the end of converter cycle 62.
// - Fast mode signals completion at the end of converter cycle 24.
// - Legacy mode calibrates the capacitors by itself after power-up.
// - That power-up calibration lasts 105 converter cycles.
// - No conversion runs while the power-up calibration is running.
// - Fast mode calibrates only on a host calibration command word.
// - Fast mode accepts a conversion from the first cycle after power-up.
// - Legacy conversion starts when chip select and write go low together.
// - Fast conversion starts on the end of a write carrying the convert word.
// - Legacy sampling covers converter cycles 41 through 49.
// - Fast sampling covers converter cycles 3 through 10.
// - Completion output goes low once the result is ready.
// - A new request is taken right after completion, no recovery.
// - A request during a conversion aborts it and restarts from cycle one.
// - Legacy abort before sampling keeps the same capacitor for the restart.
// - Legacy abort after sampling began moves to the next capacitor.
// - Mode select low means legacy mode, high means fast mode.
// - Completion output clears on a select-read or select-write low edge.
// - Legacy conversions rotate calibration through seven capacitors.
// - Select, write and status low together reset logic and abort.
module adc_conversion_sequencer (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic mode_sel,
  input wire adc_seq_pkg::host_bus_t bus,
  output logic int_n,
  output logic conv_busy,
  output logic sampling,
  output logic cal_busy,
  output logic [2:0] cal_cap,
  output logic conv_done
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    adc_seq_pkg::seq_state_t fsm;
    logic [`CYC_W-1:0] cyc;
    logic fast;
    logic [2:0] cap;
    logic adv_pending;
    logic int_n;
    logic done;
    logic sampling;
  } seq_t;

  seq_t cur;
  seq_t next_cur;

  adc_seq_pkg::strobe_ev_t ev;
  logic tick;
  logic restart;
  logic fast_mode;
  logic start_req;
  logic cal_req;
  logic start_ok;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [2:0] next_cap(input logic [2:0] c);
    if (c == `NUM_CAPS - 3'd1) begin
      next_cap = 3'd0;
    end else begin
      next_cap = c + 3'd1;
    end
  endfunction : next_cap

  function automatic logic in_window(
    input logic [`CYC_W-1:0] c,
    input logic [`CYC_W-1:0] lo,
    input logic [`CYC_W-1:0] hi
  );
    in_window = (c >= lo) && (c <= hi);
  endfunction : in_window

  function automatic logic [`CYC_W-1:0] last_cycle(input logic f);
    if (f) begin
      last_cycle = `FAST_CONV_CYC;
    end else begin
      last_cycle = `LEGACY_CONV_CYC;
    end
  endfunction : last_cycle

  // ****************************************
  // Submodules
  // ****************************************
  strobe_decode u_strobe (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .bus(bus),
    .ev(ev)
  );

  conv_clock_div u_div (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .restart(restart),
    .tick(tick)
  );

  // ****************************************
  // Request decode
  // ****************************************
  assign fast_mode = mode_sel;

  always_comb begin
    if (fast_mode) begin
      // The command word is read when the write ends
      start_req = ev.wr_rise && (ev.cmd == `CMD_CONVERT);
    end else begin
      start_req = ev.wr_fall && !ev.stat_wr;
    end
  end

  assign cal_req = fast_mode && ev.wr_rise && (ev.cmd == `CMD_CALIBRATE);

  always_comb begin
    if (fast_mode) begin
      // Accepted even before any calibration has been done
      start_ok = 1'b1;
    end else begin
      // Power-up and its calibration lock out conversions
      start_ok = (cur.fsm == adc_seq_pkg::ST_IDLE) ||
                 (cur.fsm == adc_seq_pkg::ST_CONV);
    end
  end

  assign restart = !ev.stat_wr && ((start_req && start_ok) || cal_req);

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    next_cur = cur;
    next_cur.done = 1'b0;

    // Clear first so that a completion in the same cycle wins
    if (ev.rd_fall || ev.wr_fall) begin
      next_cur.int_n = 1'b1;
    end

    case (cur.fsm)
      adc_seq_pkg::ST_POWERUP: begin
        if (fast_mode) begin
          next_cur.fsm = adc_seq_pkg::ST_IDLE;
        end else begin
          next_cur.fsm = adc_seq_pkg::ST_CAL;
          next_cur.cyc = `CYC_W'(1);
        end
      end
      adc_seq_pkg::ST_CAL: begin
        if (tick) begin
          if (cur.cyc == `PWRUP_CAL_CYC) begin
            next_cur.fsm = adc_seq_pkg::ST_IDLE;
            next_cur.cyc = '0;
          end else begin
            next_cur.cyc = cur.cyc + `CYC_W'(1);
          end
        end
      end
      adc_seq_pkg::ST_CONV: begin
        if (tick) begin
          if (cur.cyc == last_cycle(cur.fast)) begin
            next_cur.fsm = adc_seq_pkg::ST_IDLE;
            next_cur.cyc = '0;
            next_cur.done = 1'b1;
            next_cur.int_n = 1'b0;
          end else begin
            next_cur.cyc = cur.cyc + `CYC_W'(1);
          end
        end
      end
      adc_seq_pkg::ST_IDLE: begin
        next_cur.cyc = '0;
      end
      default: begin
        next_cur.fsm = adc_seq_pkg::ST_IDLE;
        next_cur.cyc = '0;
      end
    endcase

    // Once legacy sampling begins this capacitor's turn is used up
    if ((next_cur.fsm == adc_seq_pkg::ST_CONV) && !cur.fast &&
        (next_cur.cyc == `LEGACY_SAMP_FIRST)) begin
      next_cur.adv_pending = 1'b1;
    end

    if (ev.stat_wr) begin
      // Status write beats every other request in the same cycle
      next_cur.fsm = adc_seq_pkg::ST_IDLE;
      next_cur.cyc = '0;
      next_cur.cap = 3'd0;
      next_cur.adv_pending = 1'b0;
      next_cur.int_n = 1'b1;
      next_cur.done = 1'b0;
    end else if (start_req && start_ok) begin
      // Restart from cycle one, aborting any running sequence
      next_cur.fsm = adc_seq_pkg::ST_CONV;
      next_cur.cyc = `CYC_W'(1);
      next_cur.fast = fast_mode;
      if (next_cur.adv_pending) begin
        next_cur.cap = next_cap(cur.cap);
        next_cur.adv_pending = 1'b0;
      end else begin
        next_cur.cap = cur.cap;
      end
    end else if (cal_req) begin
      next_cur.fsm = adc_seq_pkg::ST_CAL;
      next_cur.cyc = `CYC_W'(1);
      next_cur.fast = 1'b1;
    end

    // Sampling window follows the cycle that will be running
    if (next_cur.fsm != adc_seq_pkg::ST_CONV) begin
      next_cur.sampling = 1'b0;
    end else if (next_cur.fast) begin
      next_cur.sampling = in_window(next_cur.cyc, `FAST_SAMP_FIRST,
                                    `FAST_SAMP_LAST);
    end else begin
      next_cur.sampling = in_window(next_cur.cyc, `LEGACY_SAMP_FIRST,
                                    `LEGACY_SAMP_LAST);
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cur.fsm <= adc_seq_pkg::ST_POWERUP;
      cur.cyc <= '0;
      cur.fast <= 1'b0;
      cur.cap <= 3'd0;
      cur.adv_pending <= 1'b0;
      cur.int_n <= 1'b1;
      cur.done <= 1'b0;
      cur.sampling <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign int_n = cur.int_n;
  assign conv_busy = (cur.fsm == adc_seq_pkg::ST_CONV);
  assign cal_busy = (cur.fsm == adc_seq_pkg::ST_CAL) ||
                    (cur.fsm == adc_seq_pkg::ST_POWERUP);
  assign sampling = cur.sampling;
  assign cal_cap = cur.cap;
  assign conv_done = cur.done;

endmodule : adc_conversion_sequencer
`default_nettype wire

// ==== shared/adc_seq_cfg.svh ====
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH

// ****************************************
// Converter clock
// ****************************************
`define SYS_CLK_NS 10
`define CONV_CLK_NS 400
`define DIV_COUNT (`CONV_CLK_NS / `SYS_CLK_NS)
`define DIV_W 6

// ****************************************
// Sequence lengths, in converter clock cycles
// ****************************************
`define CYC_W 7
`define PWRUP_CAL_CYC 7'd105
`define LEGACY_CONV_CYC 7'd62
`define FAST_CONV_CYC 7'd24
`define LEGACY_SAMP_FIRST 7'd41
`define LEGACY_SAMP_LAST 7'd49
`define FAST_SAMP_FIRST 7'd3
`define FAST_SAMP_LAST 7'd10

// ****************************************
// Capacitor rotation and fast-mode command word
// ****************************************
`define NUM_CAPS 3'd7
`define CMD_W 6
`define CMD_CONVERT 6'h01
`define CMD_CALIBRATE 6'h02

`endif

// ==== shared/adc_seq_pkg.sv ====
`include "adc_seq_cfg.svh"

package adc_seq_pkg;

  // ****************************************
  // Host bus as seen at the pins
  // ****************************************
  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic status_n;
    logic [`CMD_W-1:0] data;
  } host_bus_t;

  // ****************************************
  // Decoded strobe events
  // ****************************************
  typedef struct packed {
    logic wr_fall;
    logic wr_rise;
    logic rd_fall;
    logic stat_wr;
    logic [`CMD_W-1:0] cmd;
  } strobe_ev_t;

  typedef enum logic [1:0] {
    ST_POWERUP = 2'b00,
    ST_CAL = 2'b01,
    ST_IDLE = 2'b10,
    ST_CONV = 2'b11
  } seq_state_t;

endpackage : adc_seq_pkg

// ==== hw/conv_clock_div.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_cfg.svh"

module conv_clock_div (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic restart,
  output logic tick
);

  typedef struct packed {
    logic [`DIV_W-1:0] cnt;
  } div_state_t;

  localparam logic [`DIV_W-1:0] LAST = `DIV_W'(`DIV_COUNT - 1);

  div_state_t cur;
  div_state_t next_cur;

  // Restart realigns the phase so cycle 1 of a requested sequence is always whole
  assign tick = (cur.cnt == LAST) && !restart;

  always_comb begin
    next_cur = cur;
    if (restart || tick) begin
      next_cur.cnt = '0;
    end else begin
      next_cur.cnt = cur.cnt + `DIV_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

endmodule : conv_clock_div
`default_nettype wire

// ==== hw/strobe_decode.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_cfg.svh"

module strobe_decode (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire adc_seq_pkg::host_bus_t bus,
  output adc_seq_pkg::strobe_ev_t ev
);

  typedef struct packed {
    logic wr_act;
    logic rd_act;
    logic stat_seen;
    logic [`CMD_W-1:0] cmd;
  } dec_state_t;

  dec_state_t cur;
  dec_state_t next_cur;
  logic wr_act;
  logic rd_act;

  assign wr_act = !bus.cs_n && !bus.wr_n;
  assign rd_act = !bus.cs_n && !bus.rd_n;

  always_comb begin
    next_cur = cur;
    next_cur.wr_act = wr_act;
    next_cur.rd_act = rd_act;
    if (wr_act) begin
      // Word is taken while the write is held, so it is stable at the rise
      next_cur.cmd = bus.data;
      if (!bus.status_n) begin
        next_cur.stat_seen = 1'b1;
      end
    end else begin
      next_cur.stat_seen = 1'b0;
    end
  end

  always_comb begin
    ev.wr_fall = wr_act && !cur.wr_act;
    ev.stat_wr = wr_act && !bus.status_n && !cur.stat_seen;
    // A status write never ends as a command write
    ev.wr_rise = !wr_act && cur.wr_act && !cur.stat_seen;
    ev.rd_fall = rd_act && !cur.rd_act;
    ev.cmd = cur.cmd;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

endmodule : strobe_decode
`default_nettype wire

// ==== bench/seq_props.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_cfg.svh"
// ****
// Port checker
// ****
module seq_props (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic mode_sel,
  input wire adc_seq_pkg::host_bus_t bus,
  input wire logic int_n,
  input wire logic conv_busy,
  input wire logic sampling,
  input wire logic cal_busy,
  input wire logic [2:0] cal_cap,
  input wire logic conv_done
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic wr_lo;
  assign wr_lo = !bus.cs_n && !bus.wr_n;
  a_done_int_low: assert property (conv_done |-> !int_n)
    else $error("completion without int_n low");
  a_done_ends_busy: assert property (conv_done |-> !conv_busy && $past(conv_busy))
    else $error("completion outside a sequence");
  a_cal_blocks_conv: assert property (!mode_sel && cal_busy |-> !conv_busy)
    else $error("conversion during calibration");
  a_samp_in_conv: assert property (sampling |-> conv_busy)
    else $error("sampling outside conversion");
  a_cap_in_range: assert property (cal_cap <= 3'h6)
    else $error("capacitor index out of range");
  a_status_write_clears: assert property ((wr_lo && !bus.status_n) [*3]
    |-> !conv_busy && int_n && cal_cap == 3'h0) else $error("status write not obeyed");
  // Completion in the same cycle keeps int_n low, so it is excluded
  a_read_clears_int: assert property ($fell(bus.cs_n || bus.rd_n) && !conv_done
    |-> ##[1:2] (int_n || conv_done)) else $error("int_n not cleared by read");
  a_legacy_start_busy: assert property (!mode_sel && !cal_busy && bus.status_n
    && $fell(bus.cs_n || bus.wr_n) |-> ##[1:2] conv_busy) else $error("legacy start lost");
  a_fast_start_busy: assert property (mode_sel && $rose(bus.cs_n || bus.wr_n)
    && $past(bus.data) == `CMD_CONVERT && $past(bus.status_n) |-> ##[1:2] conv_busy)
    else $error("fast start lost");
  c_legacy_done: cover property (conv_done && !mode_sel);
  c_fast_done: cover property (conv_done && mode_sel);
  c_cal_end: cover property ($fell(cal_busy));
  c_fast_samp: cover property (sampling && mode_sel);
endmodule : seq_props

bind adc_conversion_sequencer seq_props chk_i (.clk_sys, .sys_rst, .mode_sel, .bus,
  .int_n, .conv_busy, .sampling, .cal_busy, .cal_cap, .conv_done);
`default_nettype wire

// ==== bench/host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****
// Host bus master
// ****
module host_model (
  input wire logic clk_sys,
  output adc_seq_pkg::host_bus_t bus
);
  initial bus = '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, status_n: 1'b1, data: 6'h00};
  // Strobe held 50 ns and data kept 50 ns past the rise
  task wr(input logic [5:0] d, input logic st_n);
    @(negedge clk_sys);
    bus.data = d;
    bus.status_n = st_n;
    bus.cs_n = 1'b0;
    bus.wr_n = 1'b0;
    repeat (5) @(negedge clk_sys);
    bus.cs_n = 1'b1;
    bus.wr_n = 1'b1;
    bus.status_n = 1'b1;
    repeat (5) @(negedge clk_sys);
    // Released lines must not look like the last word
    bus.data = ~d;
  endtask : wr
  task rd;
    @(negedge clk_sys);
    bus.cs_n = 1'b0;
    bus.rd_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    bus.cs_n = 1'b1;
    bus.rd_n = 1'b1;
  endtask : rd
endmodule : host_model
`default_nettype wire

// ==== bench/adc_conversion_sequencer_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_cfg.svh"
// ****
// Bench
// ****
module adc_conversion_sequencer_bench;
  localparam int D = 40;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic mode_sel = 1'b0;
  adc_seq_pkg::host_bus_t bus;
  logic int_n;
  logic conv_busy;
  logic sampling;
  logic cal_busy;
  logic [2:0] cal_cap;
  logic conv_done;
  int num_errors = 0;
  int checks = 0;
  int n;
  always #5 clk_sys = ~clk_sys;
  host_model host (.clk_sys, .bus);
  adc_conversion_sequencer dut (.clk_sys, .sys_rst, .mode_sel, .bus, .int_n, .conv_busy,
    .sampling, .cal_busy, .cal_cap, .conv_done);
  task summarize;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  task chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // Slack covers strobe length, never a whole converter cycle
  task near(input int e);
    chk(8'(n >= e - 11 && n <= e + 2), 8'h01);
  endtask : near
  function logic sig(input int w);
    case (w)
      0: sig = conv_done;
      1: sig = sampling;
      2: sig = !sampling;
      default: sig = !cal_busy;
    endcase
  endfunction : sig
  task tw(input int w);
    n = 0;
    while (sig(w) !== 1'b1) begin
      @(negedge clk_sys);
      n++;
      if (n > 9000) begin
        num_errors++;
        summarize();
      end
    end
  endtask : tw
  task rst(input logic m);
    mode_sel = m;
    sys_rst = 1'b1;
    repeat (5) @(negedge clk_sys);
    sys_rst = 1'b0;
  endtask : rst
  task t_pwr;
    rst(1'b0);
    chk({int_n, conv_busy, cal_busy}, 8'h05);
    host.wr(6'h00, 1'b1);
    chk(conv_busy, 8'h00);
    tw(3);
    near(105 * D);
    $display("power-up test done");
  endtask : t_pwr
  task t_conv(input int i);
    host.wr(6'h00, 1'b1);
    chk(cal_cap, 8'(i % 7));
    chk(int_n, 8'h01);
    tw(1);
    near(40 * D);
    tw(2);
    near(9 * D);
    tw(0);
    near(13 * D);
    chk(int_n, 8'h00);
    $display("legacy conversion done");
  endtask : t_conv
  task t_abort;
    host.wr(6'h00, 1'b1);
    chk(cal_cap, 8'h01);
    repeat (20 * D) @(negedge clk_sys);
    host.wr(6'h00, 1'b1);
    chk(cal_cap, 8'h01);
    repeat (44 * D) @(negedge clk_sys);
    host.wr(6'h00, 1'b1);
    chk(cal_cap, 8'h02);
    tw(0);
    near(62 * D);
    host.rd();
    chk(int_n, 8'h01);
    host.wr(6'h00, 1'b1);
    repeat (D) @(negedge clk_sys);
    host.wr(6'h00, 1'b0);
    chk({conv_busy, int_n, cal_cap}, 8'h08);
    $display("abort test done");
  endtask : t_abort
  task t_fast;
    rst(1'b1);
    host.wr(`CMD_CONVERT, 1'b1);
    chk(conv_busy, 8'h01);
    tw(1);
    near(2 * D);
    tw(2);
    near(8 * D);
    tw(0);
    near(14 * D);
    chk(int_n, 8'h00);
    host.rd();
    chk(int_n, 8'h01);
    host.wr(6'h3F, 1'b1);
    chk({conv_busy, cal_busy}, 8'h00);
    host.wr(`CMD_CALIBRATE, 1'b1);
    chk(cal_busy, 8'h01);
    tw(3);
    near(105 * D);
    host.wr(`CMD_CONVERT, 1'b1);
    repeat (5 * D) @(negedge clk_sys);
    host.wr(`CMD_CONVERT, 1'b1);
    tw(0);
    near(24 * D);
    $display("fast mode test done");
  endtask : t_fast
  initial begin
    t_pwr();
    for (int i = 0; i < 8; i++) begin
      t_conv(i);
    end
    t_abort();
    t_fast();
    summarize();
  end
endmodule : adc_conversion_sequencer_bench
`default_nettype wire
